// ==== core/xdsp_pkg.sv ====
// Package with register map, field layout, reset values and timing counts of the stretch block.
package xdsp_pkg;

  // Special function register locations.
  localparam logic [7:0] XDSP_ADDR_PTR0_LO = 8'h82;
  localparam logic [7:0] XDSP_ADDR_PTR0_HI = 8'h83;
  localparam logic [7:0] XDSP_ADDR_PTR1_LO = 8'h84;
  localparam logic [7:0] XDSP_ADDR_PTR1_HI = 8'h85;
  localparam logic [7:0] XDSP_ADDR_CHOICE  = 8'h86;
  localparam logic [7:0] XDSP_ADDR_CKCTL   = 8'h8E;

  // Field positions inside the clock and stretch control register and the pointer choice register.
  localparam int XDSP_STR_LSB = 0;
  localparam int XDSP_STR_MSB = 2;
  localparam int XDSP_T0_BIT  = 3;
  localparam int XDSP_T1_BIT  = 4;
  localparam int XDSP_T2_BIT  = 5;
  localparam int XDSP_SEL_BIT = 0;

  // Values after reset.
  localparam logic [2:0]  XDSP_STRETCH_RST = 3'h1;
  localparam logic [2:0]  XDSP_TSPEED_RST  = 3'h0;
  localparam logic        XDSP_SEL_RST     = 1'b0;
  localparam logic [15:0] XDSP_PTR_RST     = 16'h0000;

  // Machine cycle and data move timing, in clocks except XDSP_BASE_MC, which counts machine cycles.
  localparam int XDSP_CLK_PER_MC   = 4;
  localparam int XDSP_BASE_MC      = 2;
  localparam int XDSP_STROBE_FIRST = 4;
  localparam int XDSP_STROBE_BASE  = 2;
  localparam int XDSP_STROBE_STEP  = 4;
  localparam int XDSP_ADDR_CLKS    = 2;
  localparam int XDSP_SYNC_LAG     = 2;

  // Program fetch timing, in clocks; one machine cycle whatever the stretch.
  localparam int XDSP_FETCH_LAST   = 3;
  localparam int XDSP_PSEN_FIRST   = 1;
  localparam int XDSP_PSEN_LAST    = 2;

  // Timer advance rates, in clocks, and the number of timers.
  localparam int XDSP_TIMER_FAST   = 4;
  localparam int XDSP_TIMER_SLOW   = 12;
  localparam int XDSP_NUM_TIMERS   = 3;

  typedef enum logic [2:0] {
    XDSP_ST_IDLE  = 3'b001,
    XDSP_ST_MOVE  = 3'b010,
    XDSP_ST_FETCH = 3'b100
  } xdsp_state_t;

endpackage

// ==== core/xdsp_stretch_ctrl.sv ====
// External data move stretch control, dual data pointers and timer rate bits.
module xdsp_stretch_ctrl
  import xdsp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_ack,
  input  wire logic        move_req,
  input  wire logic        move_write,
  input  wire logic [7:0]  move_wdata,
  input  wire logic        ptr_inc,
  output logic      [7:0]  move_rdata,
  output logic             move_done,
  input  wire logic        fetch_req,
  input  wire logic [15:0] fetch_addr,
  output logic      [7:0]  fetch_rdata,
  output logic             fetch_done,
  output logic             bus_busy,
  output logic             ale,
  output logic             rd_n,
  output logic             wr_n,
  output logic             psen_n,
  input  wire logic [7:0]  port0_in,
  output logic      [7:0]  port0_out,
  output logic             port0_oe,
  output logic      [7:0]  port2_out,
  output logic      [2:0]  timer_tick
);

  xdsp_state_t state_reg;
  xdsp_state_t state_next;
  logic [1:0]  phase_reg;
  logic [5:0]  cnt_reg;
  logic [5:0]  cnt_next;
  logic [2:0]  stretch_reg;
  logic [2:0]  tspeed_reg;
  logic        sel_reg;
  logic [15:0] ptr0_reg;
  logic [15:0] ptr1_reg;
  logic [2:0]  mv_str_reg;
  logic        mv_write_reg;
  logic [7:0]  mv_wdata_reg;
  logic [15:0] addr_reg;
  logic [7:0]  port0_sync;
  logic [5:0]  mv_last;
  logic [5:0]  strobe_last;
  logic [5:0]  cap_cnt;
  logic        take_move;
  logic        take_fetch;
  logic        ale_next;
  logic        rd_n_next;
  logic        wr_n_next;
  logic        psen_n_next;
  logic [7:0]  p0_out_next;
  logic        p0_oe_next;
  logic [15:0] addr_next;

  xdsp_sync2 #(
    .WIDTH (8)
  ) u_port0_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_in   (port0_in),
    .pin_sync (port0_sync)
  );

  // One divider per timer, each steered by its own speed bit.
  for (genvar t = 0; t < XDSP_NUM_TIMERS; t++) begin : g_timer
    xdsp_timer_rate #(
      .FAST_DIV (XDSP_TIMER_FAST),
      .SLOW_DIV (XDSP_TIMER_SLOW)
    ) u_rate (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .fast_sel (tspeed_reg[t]),
      .tick     (timer_tick[t])
    );
  end

  // Machine cycle phase runs free so every cycle carries one latch pulse.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Register file writes.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stretch_reg <= XDSP_STRETCH_RST;
      tspeed_reg  <= XDSP_TSPEED_RST;
      sel_reg     <= XDSP_SEL_RST;
    end else if (sfr_wr) begin
      if (sfr_addr == XDSP_ADDR_CKCTL) begin
        stretch_reg <= sfr_wdata[XDSP_STR_MSB:XDSP_STR_LSB];
        tspeed_reg  <= {sfr_wdata[XDSP_T2_BIT], sfr_wdata[XDSP_T1_BIT],
                        sfr_wdata[XDSP_T0_BIT]};
      end
      if (sfr_addr == XDSP_ADDR_CHOICE) begin
        sel_reg <= sfr_wdata[XDSP_SEL_BIT];
      end
    end
  end

  // A byte write in the same cycle as an increment wins for that byte.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr0_reg <= XDSP_PTR_RST;
    end else begin
      if (ptr_inc && !sel_reg) begin
        ptr0_reg <= ptr0_reg + 16'h0001;
      end
      if (sfr_wr && sfr_addr == XDSP_ADDR_PTR0_LO) begin
        ptr0_reg[7:0] <= sfr_wdata;
      end
      if (sfr_wr && sfr_addr == XDSP_ADDR_PTR0_HI) begin
        ptr0_reg[15:8] <= sfr_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr1_reg <= XDSP_PTR_RST;
    end else begin
      if (ptr_inc && sel_reg) begin
        ptr1_reg <= ptr1_reg + 16'h0001;
      end
      if (sfr_wr && sfr_addr == XDSP_ADDR_PTR1_LO) begin
        ptr1_reg[7:0] <= sfr_wdata;
      end
      if (sfr_wr && sfr_addr == XDSP_ADDR_PTR1_HI) begin
        ptr1_reg[15:8] <= sfr_wdata;
      end
    end
  end

  // Register reads answer one cycle later; unmapped locations read zero without an ack.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
      sfr_ack   <= 1'b0;
    end else begin
      sfr_ack <= 1'b0;
      if (sfr_rd) begin
        sfr_ack <= 1'b1;
        case (sfr_addr)
          XDSP_ADDR_PTR0_LO: sfr_rdata <= ptr0_reg[7:0];
          XDSP_ADDR_PTR0_HI: sfr_rdata <= ptr0_reg[15:8];
          XDSP_ADDR_PTR1_LO: sfr_rdata <= ptr1_reg[7:0];
          XDSP_ADDR_PTR1_HI: sfr_rdata <= ptr1_reg[15:8];
          XDSP_ADDR_CHOICE:  sfr_rdata <= {7'h00, sel_reg};
          XDSP_ADDR_CKCTL:   sfr_rdata <= {2'h0, tspeed_reg, stretch_reg};
          default: begin
            sfr_rdata <= 8'h00;
            sfr_ack   <= 1'b0;
          end
        endcase
      end else if (sfr_wr) begin
        sfr_ack <= (sfr_addr == XDSP_ADDR_PTR0_LO) || (sfr_addr == XDSP_ADDR_PTR0_HI) ||
                   (sfr_addr == XDSP_ADDR_PTR1_LO) || (sfr_addr == XDSP_ADDR_PTR1_HI) ||
                   (sfr_addr == XDSP_ADDR_CHOICE)  || (sfr_addr == XDSP_ADDR_CKCTL);
      end
    end
  end

  // Transfers start on the clock before phase 0 so clock 0 of a transfer meets a latch pulse.
  assign take_move  = (state_reg == XDSP_ST_IDLE) && (phase_reg == 2'h3) && move_req;
  assign take_fetch = (state_reg == XDSP_ST_IDLE) && (phase_reg == 2'h3) && !move_req &&
                      fetch_req;

  // Timing of the move in flight comes from the stretch captured at its start.
  assign mv_last = 6'(XDSP_CLK_PER_MC * (XDSP_BASE_MC + int'(mv_str_reg)) - 1);
  assign strobe_last = (mv_str_reg == 3'h0) ?
    6'(XDSP_STROBE_FIRST + XDSP_STROBE_BASE - 1) :
    6'(XDSP_STROBE_FIRST + XDSP_STROBE_STEP * int'(mv_str_reg) - 1);
  assign cap_cnt = 6'(int'(strobe_last) + XDSP_SYNC_LAG);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      XDSP_ST_IDLE: begin
        cnt_next = 6'h00;
        if (take_move) begin
          state_next = XDSP_ST_MOVE;
        end else if (take_fetch) begin
          state_next = XDSP_ST_FETCH;
        end
      end
      XDSP_ST_MOVE: begin
        if (cnt_reg == mv_last) begin
          state_next = XDSP_ST_IDLE;
          cnt_next   = 6'h00;
        end else begin
          cnt_next = cnt_reg + 6'h01;
        end
      end
      XDSP_ST_FETCH: begin
        if (cnt_reg == 6'(XDSP_FETCH_LAST)) begin
          state_next = XDSP_ST_IDLE;
          cnt_next   = 6'h00;
        end else begin
          cnt_next = cnt_reg + 6'h01;
        end
      end
      default: begin
        state_next = XDSP_ST_IDLE;
        cnt_next   = 6'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= XDSP_ST_IDLE;
      cnt_reg   <= 6'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Move context is frozen at the start so later writes cannot bend a move in flight.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mv_str_reg   <= XDSP_STRETCH_RST;
      mv_write_reg <= 1'b0;
      mv_wdata_reg <= 8'h00;
      addr_reg     <= 16'h0000;
    end else if (take_move) begin
      mv_str_reg   <= stretch_reg;
      mv_write_reg <= move_write;
      mv_wdata_reg <= move_wdata;
      addr_reg     <= sel_reg ? ptr1_reg : ptr0_reg;
    end else if (take_fetch) begin
      addr_reg <= fetch_addr;
    end
  end

  // Pin values for the coming clock, built from the next state and count.
  always_comb begin
    ale_next    = (phase_reg == 2'h3);
    rd_n_next   = 1'b1;
    wr_n_next   = 1'b1;
    psen_n_next = 1'b1;
    p0_out_next = port0_out;
    p0_oe_next  = 1'b0;
    addr_next   = take_move ? (sel_reg ? ptr1_reg : ptr0_reg) :
                  (take_fetch ? fetch_addr : addr_reg);
    case (state_next)
      XDSP_ST_MOVE: begin
        if (cnt_next < 6'(XDSP_ADDR_CLKS)) begin
          p0_out_next = addr_next[7:0];
          p0_oe_next  = 1'b1;
        end else if (take_move ? move_write : mv_write_reg) begin
          p0_out_next = take_move ? move_wdata : mv_wdata_reg;
          p0_oe_next  = cnt_next <= strobe_last + 6'h01;
        end
        if (cnt_next >= 6'(XDSP_STROBE_FIRST) && cnt_next <= strobe_last) begin
          wr_n_next = !mv_write_reg;
          rd_n_next = mv_write_reg;
        end
      end
      XDSP_ST_FETCH: begin
        if (cnt_next < 6'(XDSP_PSEN_FIRST)) begin
          p0_out_next = addr_next[7:0];
          p0_oe_next  = 1'b1;
        end
        if (cnt_next >= 6'(XDSP_PSEN_FIRST) && cnt_next <= 6'(XDSP_PSEN_LAST)) begin
          psen_n_next = 1'b0;
        end
      end
      default: begin
        p0_oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ale       <= 1'b0;
      rd_n      <= 1'b1;
      wr_n      <= 1'b1;
      psen_n    <= 1'b1;
      port0_out <= 8'h00;
      port0_oe  <= 1'b0;
      port2_out <= 8'h00;
      bus_busy  <= 1'b0;
    end else begin
      ale       <= ale_next;
      rd_n      <= rd_n_next;
      wr_n      <= wr_n_next;
      psen_n    <= psen_n_next;
      port0_out <= p0_out_next;
      port0_oe  <= p0_oe_next;
      port2_out <= addr_next[15:8];
      bus_busy  <= (state_next != XDSP_ST_IDLE);
    end
  end

  // Read data are taken after the strobe, once the synchroniser has caught up with it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      move_rdata  <= 8'h00;
      move_done   <= 1'b0;
      fetch_rdata <= 8'h00;
      fetch_done  <= 1'b0;
    end else begin
      move_done  <= (state_reg == XDSP_ST_MOVE) && (cnt_reg == mv_last);
      fetch_done <= (state_reg == XDSP_ST_FETCH) && (cnt_reg == 6'(XDSP_FETCH_LAST));
      if ((state_reg == XDSP_ST_MOVE) && !mv_write_reg && (cnt_reg == cap_cnt)) begin
        move_rdata <= port0_sync;
      end
      if ((state_reg == XDSP_ST_FETCH) && (cnt_reg == 6'(XDSP_FETCH_LAST))) begin
        fetch_rdata <= port0_sync;
      end
    end
  end

endmodule // xdsp_stretch_ctrl

// ==== core/xdsp_sync2.sv ====
// Two flip-flop synchroniser for the multiplexed bus input pins.
module xdsp_sync2
  import xdsp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage1_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("xdsp_sync2: WIDTH must be at least one");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      pin_sync   <= '0;
    end else begin
      stage1_reg <= pin_in;
      pin_sync   <= stage1_reg;
    end
  end

endmodule // xdsp_sync2

// ==== core/xdsp_timer_rate.sv ====
// Timer advance pulse generator with a selectable fast or slow clock divide.
module xdsp_timer_rate
  import xdsp_pkg::*;
#(
  parameter int FAST_DIV = XDSP_TIMER_FAST,
  parameter int SLOW_DIV = XDSP_TIMER_SLOW
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic fast_sel,
  output logic      tick
);

  logic [3:0] div_reg;
  logic [3:0] limit;

  if (FAST_DIV < 1 || SLOW_DIV < 1 || FAST_DIV > 16 || SLOW_DIV > 16) begin : g_bad_div
    $error("xdsp_timer_rate: divides must lie between 1 and 16");
  end

  // A rate change mid-count wraps at once rather than running past the new limit.
  assign limit = fast_sel ? 4'(FAST_DIV - 1) : 4'(SLOW_DIV - 1);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 4'h0;
      tick    <= 1'b0;
    end else if (div_reg >= limit) begin
      div_reg <= 4'h0;
      tick    <= 1'b1;
    end else begin
      div_reg <= div_reg + 4'h1;
      tick    <= 1'b0;
    end
  end

endmodule // xdsp_timer_rate

// ==== testbench/xdata_stretch_dual_pointer_tb.sv ====
// Self-checking bench for the stretch, dual pointer and timer rate block.
module xdata_stretch_dual_pointer_tb import xdsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'h0, rst_n = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0, move_req = 1'h0;
  logic        move_write = 1'h0, ptr_inc = 1'h0, fetch_req = 1'h0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, move_wdata = 8'h00;
  logic [15:0] fetch_addr = 16'h0000;
  logic        sfr_ack, move_done, fetch_done, bus_busy, ale, rd_n, wr_n, psen_n, port0_oe;
  logic [7:0]  sfr_rdata, move_rdata, fetch_rdata, port0_in, port0_out, port2_out;
  logic [2:0]  timer_tick;
  int          fails = 0, checks_done = 0;
  logic [7:0]  m_ptr [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  m_mem [256];
  logic [7:0]  m_ck = 8'h01;
  logic        m_sel = 1'h0;
  logic [7:0]  regs [7] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h8E, 8'h8F};
  always #5 clk_sys = ~clk_sys;
  xdsp_stretch_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_ack(sfr_ack), .move_req(move_req), .move_write(move_write), .move_wdata(move_wdata),
    .ptr_inc(ptr_inc), .move_rdata(move_rdata), .move_done(move_done), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_rdata(fetch_rdata), .fetch_done(fetch_done),
    .bus_busy(bus_busy), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .psen_n(psen_n),
    .port0_in(port0_in), .port0_out(port0_out), .port0_oe(port0_oe), .port2_out(port2_out),
    .timer_tick(timer_tick));
  xdsp_mem_model i_mem (.clk_sys(clk_sys), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .psen_n(psen_n), .port0_out(port0_out), .port0_oe(port0_oe), .port0_in(port0_in));
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_t(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      fails++;
      $display("[FAIL] t=%0t clocks=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == XDSP_ADDR_CHOICE) return {7'h00, m_sel};
    if (a == XDSP_ADDR_CKCTL) return m_ck;
    return m_ptr[a[1:0] - 2'h2];
  endfunction
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic mp;
    mp = a inside {[8'h82:8'h86], 8'h8E};
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= w;
    sfr_rd <= !w;
    @(posedge clk_sys);
    sfr_wr <= 1'h0;
    sfr_rd <= 1'h0;
    #1;
    chk_v(sfr_ack, mp);
    if (!w && mp) chk_v(sfr_rdata, exp_rd(a));
    if (w && a == XDSP_ADDR_CHOICE) m_sel = d[0];
    else if (w && a == XDSP_ADDR_CKCTL) m_ck = d & 8'h3F;
    else if (w && mp) m_ptr[a[1:0] - 2'h2] = d;
  endtask
  // The bus request is held until the transfer shows busy, then dropped.
  task automatic run(input int ns, input logic [15:0] ea, output int n);
    n = 0;
    while (bus_busy !== 1'h1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk_v({port2_out, port0_out}, ea);
    if (ns >= 0) sfr(1'h1, XDSP_ADDR_CKCTL, {m_ck[7:3], 3'(ns)});
    n = (ns >= 0) ? 2 : 0;
    while (move_done !== 1'h1 && fetch_done !== 1'h1 && n < 60) begin
      @(posedge clk_sys);
      move_req <= 1'h0;
      fetch_req <= 1'h0;
      #1;
      n++;
    end
  endtask
  task automatic mv(input logic w, input int ns);
    int n;
    int s;
    logic [7:0] d;
    logic [7:0] ad;
    d = 8'($urandom);
    s = m_ck[2:0];
    ad = m_ptr[{m_sel, 1'h0}];
    @(posedge clk_sys);
    move_req <= 1'h1;
    move_write <= w;
    move_wdata <= d;
    run(ns, {m_ptr[{m_sel, 1'h1}], ad}, n);
    chk_t(n, 4 * (2 + s));
    if (w) m_mem[ad] = d;
    else chk_v(move_rdata, m_mem[ad]);
  endtask
  task automatic fet(input logic [15:0] a);
    int n;
    @(posedge clk_sys);
    fetch_req <= 1'h1;
    fetch_addr <= a;
    run(-1, a, n);
    chk_t(n, XDSP_CLK_PER_MC);
    chk_v(fetch_rdata, m_mem[a[7:0]]);
  endtask
  task automatic pinc();
    logic [15:0] p;
    p = {m_ptr[{m_sel, 1'h1}], m_ptr[{m_sel, 1'h0}]} + 16'h0001;
    @(posedge clk_sys);
    ptr_inc <= 1'h1;
    @(posedge clk_sys);
    ptr_inc <= 1'h0;
    {m_ptr[{m_sel, 1'h1}], m_ptr[{m_sel, 1'h0}]} = p;
  endtask
  // The first tick after a rate change may be early, so only the second gap is timed.
  task automatic tmr(input int i);
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk_sys);
        #1;
        n++;
      end while (timer_tick[i] !== 1'h1 && n < 40);
    end
    chk_t(n, m_ck[3 + i] ? XDSP_TIMER_FAST : XDSP_TIMER_SLOW);
  endtask
  task automatic conclude();
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 256; i++) m_mem[i] = 8'(i);
    void'($urandom(86755));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'h1;
    foreach (regs[i]) sfr(1'h0, regs[i], 8'h00);
    mv(1'h0, -1);
    $display("test reset done");
    foreach (regs[i]) sfr(1'h1, regs[i], 8'($urandom));
    foreach (regs[i]) sfr(1'h0, regs[i], 8'h00);
    $display("test registers done");
    for (int s = 0; s < 8; s++) begin
      sfr(1'h1, XDSP_ADDR_CKCTL, {2'h0, 3'($urandom), 3'(s)});
      mv(1'h1, -1);
      mv(1'h0, -1);
      fet(16'($urandom));
    end
    mv(1'h0, 0);
    mv(1'h0, -1);
    $display("test stretch done");
    sfr(1'h1, XDSP_ADDR_PTR1_LO, 8'hFF);
    sfr(1'h1, XDSP_ADDR_CHOICE, 8'hFF);
    pinc();
    foreach (regs[i]) sfr(1'h0, regs[i], 8'h00);
    mv(1'h1, -1);
    mv(1'h0, -1);
    sfr(1'h1, XDSP_ADDR_CHOICE, exp_rd(XDSP_ADDR_CHOICE) + 8'h01);
    mv(1'h0, -1);
    $display("test pointers done");
    for (int j = 0; j < 2; j++) begin
      sfr(1'h1, XDSP_ADDR_CKCTL, j ? 8'h10 : 8'h28);
      for (int i = 0; i < 3; i++) tmr(i);
    end
    $display("test timers done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    conclude();
  end
endmodule // xdata_stretch_dual_pointer_tb

// ==== testbench/xdsp_mem_model.sv ====
// External data and program memory model on the multiplexed bus.
module xdsp_mem_model (
  input  wire logic       clk_sys,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       psen_n,
  input  wire logic [7:0] port0_out,
  input  wire logic       port0_oe,
  output logic      [7:0] port0_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] adr_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic       oe_q   = 1'b0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i);
  always @(posedge clk_sys) begin
    // Only the latch pulse that opens a drive carries an address; later pulses may meet data.
    if (ale && port0_oe && !oe_q) adr_q <= port0_out;
    if (!wr_n) mem[adr_q] <= port0_out;
    last_q <= port0_in;
    oe_q   <= port0_oe;
  end
  // Outside a strobe the bus floats, so a changing pattern stands in for the old byte.
  assign port0_in = (!rd_n || !psen_n) ? mem[adr_q] : ~last_q;
endmodule // xdsp_mem_model

// ==== testbench/xdsp_stretch_ctrl_asserts.sv ====
// Concurrent checks on the ports of the stretch and dual pointer block.
module xdsp_stretch_ctrl_asserts
  import xdsp_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_ack,
  input wire logic       move_req,
  input wire logic       move_done,
  input wire logic       fetch_done,
  input wire logic       bus_busy,
  input wire logic       ale,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       psen_n,
  input wire logic       port0_oe,
  input wire logic [2:0] timer_tick
);
  logic [2:0] str_q;
  logic [2:0] cap_q;
  logic [5:0] lo_q;
  logic [5:0] bsy_q;
  logic       map_w;
  assign map_w = sfr_addr inside {[XDSP_ADDR_PTR0_LO:XDSP_ADDR_CHOICE], XDSP_ADDR_CKCTL};
  // The stretch is latched when a move is taken, so a later write cannot reach it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      str_q <= XDSP_STRETCH_RST;
      cap_q <= XDSP_STRETCH_RST;
    end else begin
      if (sfr_wr && sfr_addr == XDSP_ADDR_CKCTL) str_q <= sfr_wdata[2:0];
      if (!bus_busy && move_req) cap_q <= str_q;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lo_q  <= '0;
      bsy_q <= '0;
    end else begin
      lo_q  <= (!rd_n || !wr_n) ? lo_q + 6'h1 : 6'h0;
      bsy_q <= bus_busy ? bsy_q + 6'h1 : 6'h0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_ale_every_four: assert property (ale |=> !ale [*3] ##1 ale)
    else $error("address latch pulse not every four clocks");
  chk_strobe_width: assert property ((!rd_n || !wr_n) ##1 (rd_n && wr_n)
    |-> lo_q == ((cap_q == 3'h0) ? 6'h2 : {1'h0, cap_q, 2'h0}))
    else $error("strobe width wrong for stretch");
  chk_move_length: assert property (move_done |-> bsy_q == (({3'h0, cap_q} + 6'h2) << 2))
    else $error("data move length wrong for stretch");
  chk_fetch_length: assert property (fetch_done |-> bsy_q == 6'h4)
    else $error("fetch length not one machine cycle");
  chk_fetch_strobe: assert property ($fell(psen_n) |=> !psen_n ##1 psen_n)
    else $error("fetch strobe not two clocks");
  chk_busy_starts: assert property ($rose(bus_busy) |-> ale && port0_oe)
    else $error("transfer does not open with address latch");
  chk_idle_strobes: assert property (!bus_busy |-> rd_n && wr_n && psen_n)
    else $error("strobe active while idle");
  chk_reg_ack: assert property ((sfr_rd || sfr_wr) |=> sfr_ack == $past(map_w))
    else $error("register acknowledge wrong");
  chk_choice_zero: assert property (sfr_rd && sfr_addr == XDSP_ADDR_CHOICE
    |=> sfr_rdata[7:1] == 7'h00)
    else $error("pointer choice upper bits not zero");
  chk_stretch_read: assert property (sfr_rd && sfr_addr == XDSP_ADDR_CKCTL
    |=> sfr_rdata[2:0] == str_q && sfr_rdata[7:6] == 2'h0)
    else $error("stretch field read back wrong");
  chk_timer_gap: assert property (timer_tick[0]
    |=> !timer_tick[0] [*3] ##[1:9] timer_tick[0])
    else $error("timer advance spacing out of range");
  cover property (move_done && cap_q == 3'h7);
  cover property (move_done && cap_q == 3'h0);
  cover property (fetch_done);
endmodule // xdsp_stretch_ctrl_asserts

bind xdsp_stretch_ctrl xdsp_stretch_ctrl_asserts i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_ack(sfr_ack), .move_req(move_req),
  .move_done(move_done), .fetch_done(fetch_done), .bus_busy(bus_busy), .ale(ale), .rd_n(rd_n),
  .wr_n(wr_n), .psen_n(psen_n), .port0_oe(port0_oe), .timer_tick(timer_tick)
);
